// *** core/bit_defines.vh ***
`ifndef BIT_DEFINES_VH
`define BIT_DEFINES_VH

// Reset values of the program counter and the stack pointer
`define BIT_PC_RESET      16'h0000
`define BIT_SP_RESET      8'h07

// Full opcodes
`define BIT_OP_NOP        8'h00
`define BIT_OP_LONG_JUMP       8'h02
`define BIT_OP_LONG_CALL      8'h12
`define BIT_OP_RET        8'h22
`define BIT_OP_INTERRUPT_RETURN       8'h32
`define BIT_OP_JZ         8'h60
`define BIT_OP_JNZ        8'h70
`define BIT_OP_JMPI       8'h73
`define BIT_OP_SHORT_RELATIVE_JUMP       8'h80
`define BIT_OP_CJ_AI      8'hb4
`define BIT_OP_CJ_AD      8'hb5
`define BIT_OP_DJ_D       8'hd5
// Partial opcodes: low five bits, or high bits with a register field
`define BIT_OP_ABSOLUTE_CALL_LO   5'h11
`define BIT_OP_ABSOLUTE_JUMP_LO    5'h01
`define BIT_OP_CJ_IND_HI  7'h5b
`define BIT_OP_CJ_RN_HI   5'h17
`define BIT_OP_DJ_RN_HI   5'h1b

// Instruction classes
`define BIT_CL_NOP        5'h00
`define BIT_CL_ABSOLUTE_CALL      5'h01
`define BIT_CL_LONG_CALL      5'h02
`define BIT_CL_RET        5'h03
`define BIT_CL_INTERRUPT_RETURN       5'h04
`define BIT_CL_ABSOLUTE_JUMP       5'h05
`define BIT_CL_LONG_JUMP       5'h06
`define BIT_CL_SHORT_RELATIVE_JUMP       5'h07
`define BIT_CL_JMPI       5'h08
`define BIT_CL_JZ         5'h09
`define BIT_CL_JNZ        5'h0a
`define BIT_CL_CJ_AD      5'h0b
`define BIT_CL_CJ_AI      5'h0c
`define BIT_CL_CJ_RN      5'h0d
`define BIT_CL_CJ_IND     5'h0e
`define BIT_CL_DJ_RN      5'h0f
`define BIT_CL_DJ_D       5'h10
`define BIT_CL_ILL        5'h11

// Length in bytes and execution time in cycles
`define BIT_LEN_1         2'h1
`define BIT_LEN_2         2'h2
`define BIT_LEN_3         2'h3
`define BIT_CYC_1         3'h1
`define BIT_CYC_3         3'h3
`define BIT_CYC_4         3'h4
`define BIT_CYC_5         3'h5

// Cycle slots within an instruction
`define BIT_SLOT_0        3'h0
`define BIT_SLOT_1        3'h1
`define BIT_SLOT_2        3'h2

`endif

// *** core/bit_decode.v ***
`timescale 1ns/100ps
`include "bit_defines.vh"

// Opcode to class, length and cycle count; purely combinational
module bit_decode (
  // Opcode in
  input  wire [7:0] op_i,
  // Decoded fields
  output reg  [4:0] cls_o,
  output reg  [1:0] len_o,
  output reg  [2:0] cyc_o
);

  // Anything not recognised runs as a one-byte, one-cycle illegal slot
  always @* begin
    cls_o = `BIT_CL_ILL;
    len_o = `BIT_LEN_1;
    cyc_o = `BIT_CYC_1;
    if (op_i == `BIT_OP_NOP) begin
      cls_o = `BIT_CL_NOP;
    end else if (op_i[4:0] == `BIT_OP_ABSOLUTE_CALL_LO) begin
      cls_o = `BIT_CL_ABSOLUTE_CALL;
      len_o = `BIT_LEN_2;
      cyc_o = `BIT_CYC_4;
    end else if (op_i[4:0] == `BIT_OP_ABSOLUTE_JUMP_LO) begin
      cls_o = `BIT_CL_ABSOLUTE_JUMP;
      len_o = `BIT_LEN_2;
      cyc_o = `BIT_CYC_3;
    end else if (op_i == `BIT_OP_LONG_CALL) begin
      cls_o = `BIT_CL_LONG_CALL;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_RET) begin
      cls_o = `BIT_CL_RET;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_INTERRUPT_RETURN) begin
      cls_o = `BIT_CL_INTERRUPT_RETURN;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_LONG_JUMP) begin
      cls_o = `BIT_CL_LONG_JUMP;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_SHORT_RELATIVE_JUMP) begin
      cls_o = `BIT_CL_SHORT_RELATIVE_JUMP;
      len_o = `BIT_LEN_2;
      cyc_o = `BIT_CYC_3;
    end else if (op_i == `BIT_OP_JMPI) begin
      cls_o = `BIT_CL_JMPI;
      cyc_o = `BIT_CYC_5;
    end else if (op_i == `BIT_OP_JZ) begin
      cls_o = `BIT_CL_JZ;
      len_o = `BIT_LEN_2;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_JNZ) begin
      cls_o = `BIT_CL_JNZ;
      len_o = `BIT_LEN_2;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_CJ_AD) begin
      cls_o = `BIT_CL_CJ_AD;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_5;
    end else if (op_i == `BIT_OP_CJ_AI) begin
      cls_o = `BIT_CL_CJ_AI;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_4;
    end else if (op_i[7:3] == `BIT_OP_CJ_RN_HI) begin
      cls_o = `BIT_CL_CJ_RN;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_4;
    end else if (op_i[7:1] == `BIT_OP_CJ_IND_HI) begin
      cls_o = `BIT_CL_CJ_IND;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_5;
    end else if (op_i[7:3] == `BIT_OP_DJ_RN_HI) begin
      cls_o = `BIT_CL_DJ_RN;
      len_o = `BIT_LEN_2;
      cyc_o = `BIT_CYC_4;
    end else if (op_i == `BIT_OP_DJ_D) begin
      cls_o = `BIT_CL_DJ_D;
      len_o = `BIT_LEN_3;
      cyc_o = `BIT_CYC_5;
    end
  end

endmodule // bit_decode

// *** core/bit_branch_unit.v ***
`timescale 1ns/100ps
`include "bit_defines.vh"

// What this block does
// - Absolute call: two bytes, four cycles; long call: three bytes, four cycles.
// - Subroutine return and interrupt return: one byte, four cycles each.
// - Absolute jump with 11-bit target field: two bytes, three cycles.
// - Long jump with 16-bit target: three bytes, four cycles.
// - Short relative jump: two bytes, three cycles.
// - Indirect jump to accumulator plus data pointer: one byte, five cycles.
// - Jump if accumulator zero: two bytes, four cycles.
// - Jump if accumulator nonzero: two bytes, four cycles.
// - Compare direct byte with accumulator, jump if unequal: three bytes, five cycles.
// - Compare immediate with accumulator, jump if unequal: three bytes, four cycles.
// - Compare immediate with working register, jump if unequal: three bytes, four cycles.
// - Compare immediate with indirect RAM byte, jump if unequal: three bytes, five cycles.
// - Decrement working register, jump if nonzero: two bytes, four cycles.
// - Decrement direct byte, jump if nonzero: three bytes, five cycles.
// - No-operation: one byte, one cycle, only the program counter moves.
// - Multi-cycle 8-bit sequencer, one to five cycles per instruction, usable up to 67 MHz.
module bit_branch_unit (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // Program memory, read combinationally at the presented address
  output wire [15:0] code_addr_o,
  input  wire [7:0]  code_data_i,
  // Data memory, read combinationally, written at the clock edge
  output wire [7:0]  data_addr_o,
  output wire        data_rd_o,
  output wire        data_wr_o,
  output wire [7:0]  data_wdata_o,
  input  wire [7:0]  data_rdata_i,
  // Core state supplied by the rest of the core
  input  wire [7:0]  acc_i,
  input  wire [15:0] data_pointer_register_i,
  input  wire [1:0]  bank_i,
  // Status toward the core
  output wire        instr_start_o,
  output wire        carry_o,
  output wire        carry_wr_o,
  output wire        intr_ret_o,
  output wire        illegal_o,
  output wire [7:0]  sp_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////////

  // Sequencing registers
  reg  [2:0]  cnt_reg;
  reg  [2:0]  cnt_next;
  reg  [15:0] pc_reg;
  reg  [15:0] pc_next;
  reg  [7:0]  op_reg;
  reg  [7:0]  op_next;
  reg  [7:0]  b1_reg;
  reg  [7:0]  b1_next;
  reg  [7:0]  b2_reg;
  reg  [7:0]  b2_next;
  reg  [7:0]  opnd_reg;
  reg  [7:0]  opnd_next;
  reg  [7:0]  hi_reg;
  reg  [7:0]  hi_next;
  reg  [7:0]  sp_reg;
  reg  [7:0]  sp_next;

  // Output registers
  reg  [15:0] code_addr_reg;
  reg  [15:0] code_addr_next;
  reg  [7:0]  daddr_reg;
  reg  [7:0]  daddr_next;
  reg         rd_reg;
  reg         rd_next;
  reg         wr_reg;
  reg         wr_next;
  reg  [7:0]  wdata_reg;
  reg  [7:0]  wdata_next;
  reg         start_reg;
  reg         start_next;
  reg         carry_reg;
  reg         carry_next;
  reg         carry_wr_reg;
  reg         carry_wr_next;
  reg         iret_reg;
  reg         iret_next;
  reg         ill_reg;
  reg         ill_next;

  // Decode results and derived values
  wire [7:0]  cur_op;
  wire [4:0]  cls;
  wire [1:0]  len;
  wire [2:0]  cyc;
  wire        last;
  wire [15:0] ret_addr;
  wire [7:0]  rel;
  wire [15:0] rel_target;
  wire [15:0] abs_target;
  wire [7:0]  rn_addr;
  wire [7:0]  ri_addr;
  reg  [7:0]  cmp_l;
  reg  [7:0]  cmp_r;
  reg         taken;
  reg  [15:0] target;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  ////////////////////////////////////////////////////////////////////////////

  // Slot 0 decodes the byte on the code bus; later slots use the held opcode
  assign cur_op = (cnt_reg == `BIT_SLOT_0) ? code_data_i : op_reg;

  bit_decode u_decode (
    .op_i  (cur_op),
    .cls_o (cls),
    .len_o (len),
    .cyc_o (cyc)
  );

  // Final slot of the instruction; the count never depends on the outcome
  assign last = (cnt_reg == (cyc - 3'h1));

  // Address of the instruction after this one
  assign ret_addr = pc_reg + {14'h0000, len};

  // Offset is the last operand byte, sign extended
  assign rel        = (len == `BIT_LEN_2) ? b1_reg : b2_reg;
  assign rel_target = ret_addr + {{8{rel[7]}}, rel};

  // 11-bit target keeps the top five bits of the next address
  assign abs_target = {ret_addr[15:11], op_reg[7:5], b1_reg};

  // Working registers live in the selected bank of internal RAM
  assign rn_addr = {3'h0, bank_i, op_reg[2:0]};
  assign ri_addr = {3'h0, bank_i, 2'h0, op_reg[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Condition and target
  ////////////////////////////////////////////////////////////////////////////

  // Operands of the compare; the left one also sets carry when smaller
  always @* begin
    cmp_l = acc_i;
    cmp_r = b1_reg;
    if (cls == `BIT_CL_CJ_AD) begin
      cmp_r = opnd_reg;
    end else if ((cls == `BIT_CL_CJ_RN) || (cls == `BIT_CL_CJ_IND)) begin
      cmp_l = opnd_reg;
    end
  end

  // New program counter chosen in the final slot
  always @* begin
    taken  = 1'b0;
    target = ret_addr;
    case (cls)
      `BIT_CL_ABSOLUTE_CALL, `BIT_CL_ABSOLUTE_JUMP: target = abs_target;
      `BIT_CL_LONG_CALL, `BIT_CL_LONG_JUMP: target = {b1_reg, b2_reg};
      `BIT_CL_RET, `BIT_CL_INTERRUPT_RETURN: target = {hi_reg, opnd_reg};
      `BIT_CL_SHORT_RELATIVE_JUMP: target = rel_target;
      `BIT_CL_JMPI: target = data_pointer_register_i + {8'h00, acc_i};
      `BIT_CL_JZ: taken = (acc_i == 8'h00);
      `BIT_CL_JNZ: taken = (acc_i != 8'h00);
      `BIT_CL_CJ_AD, `BIT_CL_CJ_AI, `BIT_CL_CJ_RN, `BIT_CL_CJ_IND: begin
        taken = (cmp_l != cmp_r);
      end
      `BIT_CL_DJ_RN, `BIT_CL_DJ_D: taken = (opnd_reg != 8'h01);
      default: taken = 1'b0;
    endcase
    if (taken) begin
      target = rel_target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot sequencer
  ////////////////////////////////////////////////////////////////////////////

  // Each slot decides what the memories see in the next slot, so every
  // memory port comes from a flop at the cost of one slot of lead time
  always @* begin
    cnt_next       = cnt_reg + 3'h1;
    pc_next        = pc_reg;
    code_addr_next = pc_reg + {13'h0000, cnt_reg} + 16'h0001;
    op_next        = op_reg;
    b1_next        = b1_reg;
    b2_next        = b2_reg;
    opnd_next      = opnd_reg;
    hi_next        = hi_reg;
    sp_next        = sp_reg;
    daddr_next     = daddr_reg;
    rd_next        = 1'b0;
    wr_next        = 1'b0;
    wdata_next     = wdata_reg;
    start_next     = 1'b0;
    carry_next     = carry_reg;
    carry_wr_next  = 1'b0;
    iret_next      = 1'b0;
    ill_next       = 1'b0;

    // Capture opcode and operand bytes as they stream past
    if (cnt_reg == `BIT_SLOT_0) begin
      op_next = code_data_i;
    end
    if (cnt_reg == `BIT_SLOT_1) begin
      b1_next = code_data_i;
    end
    if (cnt_reg == `BIT_SLOT_2) begin
      b2_next = code_data_i;
    end

    case (cls)
      // Push return address, low byte first
      `BIT_CL_ABSOLUTE_CALL, `BIT_CL_LONG_CALL: begin
        if ((cnt_reg == `BIT_SLOT_1) || (cnt_reg == `BIT_SLOT_2)) begin
          sp_next    = sp_reg + 8'h01;
          daddr_next = sp_reg + 8'h01;
          wr_next    = 1'b1;
          wdata_next = (cnt_reg == `BIT_SLOT_1) ? ret_addr[7:0] : ret_addr[15:8];
        end
      end
      // Pop high byte, then low byte
      `BIT_CL_RET, `BIT_CL_INTERRUPT_RETURN: begin
        if (cnt_reg == `BIT_SLOT_0) begin
          daddr_next = sp_reg;
          rd_next    = 1'b1;
        end else if (cnt_reg == `BIT_SLOT_1) begin
          hi_next    = data_rdata_i;
          sp_next    = sp_reg - 8'h01;
          daddr_next = sp_reg - 8'h01;
          rd_next    = 1'b1;
        end else if (cnt_reg == `BIT_SLOT_2) begin
          opnd_next  = data_rdata_i;
          sp_next    = sp_reg - 8'h01;
        end
      end
      // Direct operand: address arrives in byte one
      `BIT_CL_CJ_AD, `BIT_CL_DJ_D: begin
        if (cnt_reg == `BIT_SLOT_1) begin
          daddr_next = code_data_i;
          rd_next    = 1'b1;
        end else if (cnt_reg == `BIT_SLOT_2) begin
          opnd_next  = data_rdata_i;
          if (cls == `BIT_CL_DJ_D) begin
            wr_next    = 1'b1;
            wdata_next = data_rdata_i - 8'h01;
          end
        end
      end
      // Working register operand
      `BIT_CL_CJ_RN, `BIT_CL_DJ_RN: begin
        if (cnt_reg == `BIT_SLOT_0) begin
          daddr_next = {3'h0, bank_i, code_data_i[2:0]};
          rd_next    = 1'b1;
        end else if (cnt_reg == `BIT_SLOT_1) begin
          opnd_next  = data_rdata_i;
          if (cls == `BIT_CL_DJ_RN) begin
            daddr_next = rn_addr;
            wr_next    = 1'b1;
            wdata_next = data_rdata_i - 8'h01;
          end
        end
      end
      // Pointer register, then the byte it points at
      `BIT_CL_CJ_IND: begin
        if (cnt_reg == `BIT_SLOT_0) begin
          daddr_next = {3'h0, bank_i, 2'h0, code_data_i[0]};
          rd_next    = 1'b1;
        end else if (cnt_reg == `BIT_SLOT_1) begin
          daddr_next = data_rdata_i;
          rd_next    = 1'b1;
        end else if (cnt_reg == `BIT_SLOT_2) begin
          opnd_next  = data_rdata_i;
        end
      end
      default: begin
        daddr_next = daddr_reg;
      end
    endcase

    // Final slot: redirect fetch and start the next instruction
    if (last) begin
      cnt_next       = `BIT_SLOT_0;
      pc_next        = target;
      code_addr_next = target;
      start_next     = 1'b1;
      iret_next      = (cls == `BIT_CL_INTERRUPT_RETURN);
      ill_next       = (cls == `BIT_CL_ILL);
      if ((cls == `BIT_CL_CJ_AD) || (cls == `BIT_CL_CJ_AI) ||
          (cls == `BIT_CL_CJ_RN) || (cls == `BIT_CL_CJ_IND)) begin
        carry_next    = (cmp_l < cmp_r);
        carry_wr_next = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////////

  // Reset lands on slot 0 of the instruction at the reset vector
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg       <= `BIT_SLOT_0;
      pc_reg        <= `BIT_PC_RESET;
      op_reg        <= `BIT_OP_NOP;
      b1_reg        <= 8'h00;
      b2_reg        <= 8'h00;
      opnd_reg      <= 8'h00;
      hi_reg        <= 8'h00;
      sp_reg        <= `BIT_SP_RESET;
      code_addr_reg <= `BIT_PC_RESET;
      daddr_reg     <= 8'h00;
      rd_reg        <= 1'b0;
      wr_reg        <= 1'b0;
      wdata_reg     <= 8'h00;
      start_reg     <= 1'b1;
      carry_reg     <= 1'b0;
      carry_wr_reg  <= 1'b0;
      iret_reg      <= 1'b0;
      ill_reg       <= 1'b0;
    end else begin
      cnt_reg       <= cnt_next;
      pc_reg        <= pc_next;
      op_reg        <= op_next;
      b1_reg        <= b1_next;
      b2_reg        <= b2_next;
      opnd_reg      <= opnd_next;
      hi_reg        <= hi_next;
      sp_reg        <= sp_next;
      code_addr_reg <= code_addr_next;
      daddr_reg     <= daddr_next;
      rd_reg        <= rd_next;
      wr_reg        <= wr_next;
      wdata_reg     <= wdata_next;
      start_reg     <= start_next;
      carry_reg     <= carry_next;
      carry_wr_reg  <= carry_wr_next;
      iret_reg      <= iret_next;
      ill_reg       <= ill_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  // All outputs are plain flop outputs
  assign code_addr_o   = code_addr_reg;
  assign data_addr_o   = daddr_reg;
  assign data_rd_o     = rd_reg;
  assign data_wr_o     = wr_reg;
  assign data_wdata_o  = wdata_reg;
  assign instr_start_o = start_reg;
  assign carry_o       = carry_reg;
  assign carry_wr_o    = carry_wr_reg;
  assign intr_ret_o    = iret_reg;
  assign illegal_o     = ill_reg;
  assign sp_o          = sp_reg;

endmodule // bit_branch_unit

// *** dv/bit_mem_model.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Program and data memory seen by the branch unit
module bit_mem_model (
  // Clock
  input  wire        clk_i,
  // Program side
  input  wire [15:0] code_addr_i,
  output wire [7:0]  code_data_o,
  // Data side
  input  wire [7:0]  data_addr_i,
  input  wire        data_wr_i,
  input  wire [7:0]  data_wdata_i,
  output wire [7:0]  data_rdata_o
);
  reg [7:0] code [0:65535];
  reg [7:0] ram  [0:255];

  // Reads answer in the same cycle; the core has no wait state to offer
  assign code_data_o  = code[code_addr_i];
  assign data_rdata_o = ram[data_addr_i];

  // Write lands at the edge that closes the strobe cycle
  always @(posedge clk_i) begin
    if (data_wr_i) begin
      ram[data_addr_i] <= data_wdata_i;
    end
  end
endmodule // bit_mem_model

// *** dv/bit_branch_chk.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Timing and target checks on the branch unit ports
module bit_branch_chk (
  // Clock and reset
  input wire        clk_i,
  input wire        rstn_i,
  // Memory side
  input wire [15:0] code_addr_o,
  input wire [7:0]  code_data_i,
  input wire [7:0]  data_addr_o,
  input wire        data_rd_o,
  input wire        data_wr_o,
  input wire [7:0]  data_wdata_o,
  // Core side
  input wire [7:0]  acc_i,
  input wire [15:0] data_pointer_register_i,
  input wire        instr_start_o,
  input wire        carry_o,
  input wire        carry_wr_o,
  input wire        intr_ret_o,
  input wire [7:0]  sp_o
);
  // Low byte of the return address a two-byte call must push
  wire [7:0] ret_lo_w = code_addr_o[7:0] + 8'h02;
  wire       st       = instr_start_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_nop_one_cycle: assert property (st && code_data_i == 8'h00 |=> st &&
    code_addr_o == $past(code_addr_o) + 16'h0001 && sp_o == $past(sp_o))
    else $error("no-op did not advance by one");
  a_long_jump_target: assert property (st && code_data_i == 8'h02 |=> !st[*3] ##1
    (st && code_addr_o == {$past(code_data_i, 3), $past(code_data_i, 2)}))
    else $error("long jump target or timing wrong");
  a_short_relative_jump_cycles: assert property (st && code_data_i == 8'h80 |=> !st[*2] ##1 st)
    else $error("short jump not three cycles");
  a_absolute_jump_cycles: assert property (st && code_data_i[4:0] == 5'h01 |=> !st ##1 !st ##1 st)
    else $error("absolute jump not three cycles");
  a_jmpi_target: assert property (st && code_data_i == 8'h73 |=> !st[*4] ##1
    (st && code_addr_o == $past(data_pointer_register_i) + {8'h00, $past(acc_i)}))
    else $error("indirect jump target or timing wrong");
  a_ret_cycles: assert property (st && code_data_i == 8'h22 |=> !st[*3] ##1 (st && !intr_ret_o))
    else $error("subroutine return not four cycles");
  a_interrupt_return_flag: assert property (st && code_data_i == 8'h32 |-> ##4 st && intr_ret_o)
    else $error("interrupt return flag missing");
  a_ret_stack_reads: assert property (st && (code_data_i == 8'h22 || code_data_i == 8'h32) |=>
    (data_rd_o && data_addr_o == sp_o) ##1 (data_rd_o && data_addr_o == sp_o) ##1 !data_rd_o)
    else $error("return stack reads wrong");
  a_call_push: assert property (st && code_data_i[4:0] == 5'h11 |-> ##2
    (data_wr_o && data_addr_o == $past(sp_o, 2) + 8'h01 && data_wdata_o == $past(ret_lo_w, 2))
    ##1 data_wr_o ##1 st) else $error("absolute call push wrong");
  a_cond_cycles: assert property (st && (code_data_i == 8'h60 || code_data_i == 8'h70)
    |=> !st[*3] ##1 st) else $error("accumulator branch not four cycles");
  a_cmp_carry: assert property (st && code_data_i == 8'hb4 |-> ##4 st && carry_wr_o &&
    carry_o == ($past(acc_i) < $past(code_data_i, 3))) else $error("compare carry wrong");
  a_decrement_jump_nonzero_reg: assert property (st && code_data_i[7:3] == 5'h1b |=> !st[*3] ##1 st)
    else $error("register decrement branch not four cycles");
  a_decrement_jump_nonzero_dir: assert property (st && code_data_i == 8'hd5 |=> !st[*4] ##1 st)
    else $error("direct decrement branch not five cycles");
endmodule // bit_branch_chk

bind bit_branch_unit bit_branch_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .code_addr_o(code_addr_o), .code_data_i(code_data_i), .data_addr_o(data_addr_o),
  .data_rd_o(data_rd_o),
  .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o), .acc_i(acc_i), .data_pointer_register_i(data_pointer_register_i),
  .instr_start_o(instr_start_o), .carry_o(carry_o), .carry_wr_o(carry_wr_o),
  .intr_ret_o(intr_ret_o), .sp_o(sp_o));

// *** dv/bit_branch_unit_tb.sv ***
`timescale 1ns/100ps
`include "bit_defines.vh"
module bit_branch_unit_tb;
  reg          clk_i  = 1'b0;
  reg          rstn_i = 1'b0;
  reg  [7:0]   acc_i  = 8'h00;
  reg  [15:0]  data_pointer_register_i = 16'h0200;
  reg  [1:0]   bank_i = 2'h0;
  wire [15:0]  code_addr_o;
  wire [7:0]   code_data_i, data_addr_o, data_wdata_o, data_rdata_i, sp_o;
  wire         data_rd_o, data_wr_o, instr_start_o, carry_o, carry_wr_o, intr_ret_o, illegal_o;
  integer      fail_count = 0;
  integer      samples_checked = 0;
  integer      seed = 3320;
  integer      mpc, msp, cyc, ecar, ecw, eir, eill, pass, i, rnd;
  reg  [7:0]   img  [0:1023];
  reg  [7:0]   mram [0:255];

  bit_branch_unit dut (.clk_i(clk_i), .rstn_i(rstn_i), .code_addr_o(code_addr_o),
    .code_data_i(code_data_i), .data_addr_o(data_addr_o), .data_rd_o(data_rd_o),
    .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o), .data_rdata_i(data_rdata_i),
    .acc_i(acc_i), .data_pointer_register_i(data_pointer_register_i), .bank_i(bank_i), .instr_start_o(instr_start_o),
    .carry_o(carry_o), .carry_wr_o(carry_wr_o), .intr_ret_o(intr_ret_o),
    .illegal_o(illegal_o), .sp_o(sp_o));
  bit_mem_model u_mem (.clk_i(clk_i), .code_addr_i(code_addr_o), .code_data_o(code_data_i),
    .data_addr_i(data_addr_o), .data_wr_i(data_wr_o), .data_wdata_i(data_wdata_o),
    .data_rdata_o(data_rdata_i));

  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reporting
  task check(input ok, input [8*16-1:0] msg);
    begin
      samples_checked = samples_checked + 1;
      if (!ok) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: %0s", $time, msg);
      end
    end
  endtask

  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model: one instruction per call, integers only
  function integer rel(input [7:0] b);
    rel = b[7] ? b - 256 : b;
  endfunction

  task push(input integer v);
    begin
      msp = msp + 1;
      mram[msp] = v[7:0];
      msp = msp + 1;
      mram[msp] = v[15:8];
    end
  endtask

  task cmp(input integer l, input integer r, input integer c, input [7:0] rb);
    begin
      ecw = 1;
      ecar = (l < r);
      cyc = c;
      mpc = mpc + 3 + ((l != r) ? rel(rb) : 0);
    end
  endtask

  task dj(input integer a, input integer n, input integer c, input [7:0] rb);
    begin
      mram[a] = mram[a] - 8'h01;
      cyc = c;
      mpc = mpc + n + ((mram[a] != 0) ? rel(rb) : 0);
    end
  endtask

  task step;
    reg [7:0] o, b1, b2;
    integer   rp;
    begin
      o = img[mpc];
      b1 = img[mpc + 1];
      b2 = img[mpc + 2];
      rp = bank_i * 8 + o[2:0];
      ecw = 0;
      eir = 0;
      eill = 0;
      casez (o)
        8'h00: begin cyc = 1; mpc = mpc + 1; end
        8'h02: begin cyc = 4; mpc = b1 * 256 + b2; end
        8'h12: begin push(mpc + 3); cyc = 4; mpc = b1 * 256 + b2; end
        8'h22, 8'h32: begin
          cyc = 4;
          eir = (o == 8'h32);
          mpc = mram[msp] * 256 + mram[msp - 1];
          msp = msp - 2;
        end
        8'h80: begin cyc = 3; mpc = mpc + 2 + rel(b1); end
        8'h73: begin cyc = 5; mpc = acc_i + data_pointer_register_i; end
        8'h60, 8'h70: begin
          cyc = 4;
          mpc = mpc + 2 + (((acc_i == 0) == (o == 8'h60)) ? rel(b1) : 0);
        end
        8'hb4: cmp(acc_i, b1, 4, b2);
        8'hb5: cmp(acc_i, mram[b1], 5, b2);
        8'hb6, 8'hb7: cmp(mram[mram[bank_i * 8 + o[0]]], b1, 5, b2);
        8'b1011_1???: cmp(mram[rp], b1, 4, b2);
        8'b1101_1???: dj(rp, 2, 4, b1);
        8'hd5: dj(b1, 3, 5, b2);
        8'b???1_0001: begin
          push(mpc + 2);
          cyc = 4;
          mpc = ((mpc + 2) & 'hf800) + o[7:5] * 256 + b1;
        end
        8'b???0_0001: begin cyc = 3; mpc = ((mpc + 2) & 'hf800) + o[7:5] * 256 + b1; end
        default: begin cyc = 1; eill = 1; mpc = mpc + 1; end
      endcase
    end
  endtask

  // Places n bytes of v, first byte highest
  task put(input integer a, input [23:0] v, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        img[a + k] = v >> (8 * (n - 1 - k));
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One program run from reset; every start is compared with the model
  task run_pass;
    integer cnt, prev, hits;
    begin
      mpc = `BIT_PC_RESET;
      msp = `BIT_SP_RESET;
      prev = 0;
      hits = 0;
      cnt = 0;
      {ecw, eir, eill, ecar} = 0;
      while (hits < 2) begin
        @(negedge clk_i);
        cnt = cnt + 1;
        if (instr_start_o === 1'b1) begin
          check(code_addr_o === mpc[15:0], "next address");
          if (prev != 0) check(cnt == prev, "cycle count");
          check(sp_o === msp[7:0], "stack pointer");
          check({carry_wr_o, intr_ret_o, illegal_o} === {ecw[0], eir[0], eill[0]}, "status");
          if (ecw) check(carry_o === ecar[0], "carry");
          if (mpc == 'h301) hits = hits + 1;
          step;
          prev = cyc;
          cnt = 0;
        end
      end
      for (i = 0; i < 256; i = i + 1) begin
        check(u_mem.ram[i] === mram[i], "data memory");
      end
    end
  endtask

  // Program: every branch kind once, converging on a self loop at 0301
  initial begin : main
    for (i = 0; i < 1024; i = i + 1) begin
      img[i] = 8'h00;
    end
    put('h000, 'h120100, 3);
    put('h100, 'h22, 1);
    put('h003, 'h3110, 2);
    put('h110, 'h32, 1);
    put('h005, 'h2120, 2);
    put('h120, 'h8010, 2);
    put('h132, 'h6005, 2);
    put('h139, 'h7003, 2);
    put('h13e, 'hb40002, 3);
    put('h143, 'hb53002, 3);
    put('h148, 'hb80502, 3);
    put('h14d, 'hb74402, 3);
    put('h152, 'hd8fe, 2);
    put('h154, 'hd531fd, 3);
    put('h157, 'h73, 1);
    put('h300, 'ha5, 1);
    put('h301, 'h020301, 3);
    for (pass = 0; pass < 4; pass = pass + 1) begin
      @(posedge clk_i);
      rstn_i <= 1'b0;
      rnd = $random(seed);
      acc_i  <= (pass == 0) ? 8'h00 : rnd[7:0];
      rnd = $random(seed);
      bank_i <= rnd[1:0];
      repeat (6) @(posedge clk_i);
      // Memories are filled while reset holds the core still
      for (i = 0; i < 1024; i = i + 1) begin
        u_mem.code[i] = img[i];
      end
      for (i = 0; i < 256; i = i + 1) begin
        rnd = $random(seed);
        mram[i] = rnd[7:0];
      end
      mram['h31] = 8'h02;
      mram[bank_i * 8] = 8'h05;
      for (i = 0; i < 256; i = i + 1) begin
        u_mem.ram[i] = mram[i];
      end
      rstn_i <= 1'b1;
      run_pass;
      $display("test %0d done, acc %h bank %0d", pass, acc_i, bank_i);
    end
    final_report;
  end

  // Watchdog: four passes need well under 8000 cycles
  initial begin
    #(20000 * 50);
    fail_count = fail_count + 1;
    $display("unexpected at %0t: run hung", $time);
    final_report;
  end
endmodule // bit_branch_unit_tb
